/* rbt_btn_host.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Buttons and host reset input
// ----------------------------------------------------------------------
// Two push buttons with pull-ups, and the host's reset input behind the
// reboot pin. The host line carries a pull-up of its own.
module rbt_btn_host (
  input  wire logic              press_first,
  input  wire logic              press_second,
  input  wire rbt_pkg::rbt_pin_t pin,
  output logic                   first_btn_n,
  output logic                   second_btn_n,
  output logic                   host_rst_n
);
  // A released button leaves its line open, so the pull-up makes it high.
  assign first_btn_n  = press_first ? 1'b0 : 1'b1;
  assign second_btn_n = press_second ? 1'b0 : 1'b1;
  // An undriven pin reads high, which hides a missing release.
  assign host_rst_n   = pin.oe ? pin.o : 1'b1;
endmodule

/* rbt_ms_timer.sv */
`timescale 1ns/1ps
// Millisecond timer: a prescaler divides the clock into millisecond ticks
// and a saturating counter adds them up until it is cleared.
module rbt_ms_timer #(
  parameter int unsigned TICK_CYCLES = rbt_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  output logic [15:0]      ms_q
);

  // Prescaler position within the current millisecond.
  logic [31:0] pre_q;
  // High in the last cycle of each millisecond.
  logic        tick;

  assign tick = (pre_q == 32'(TICK_CYCLES - 1));

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------

  // Clearing restarts the millisecond so that a count starts on a clean edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 32'h0000_0000;
    end else if (clr || tick) begin
      pre_q <= 32'h0000_0000;
    end else begin
      pre_q <= pre_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Millisecond counter
  // ----------------------------------------------------------------------

  // Saturates rather than wraps, so a late reader never sees a small value.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_q <= rbt_pkg::MS_RST;
    end else if (clr) begin
      ms_q <= rbt_pkg::MS_RST;
    end else if (tick && (ms_q != 16'hFFFF)) begin
      ms_q <= ms_q + 16'h0001;
    end
  end

endmodule

/* rbt_pkg.sv */
package rbt_pkg;

  // ----------------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------------

  // The system clock runs at 125 MHz.
  localparam int unsigned CLK_HZ        = 125000000;
  // One millisecond tick, in microseconds, as the time unit of the timers.
  localparam int unsigned TICK_US       = 1000;
  // Clock cycles per millisecond tick, derived from the rate.
  localparam int unsigned TICK_CYCLES   = (CLK_HZ / 1000000) * TICK_US;

  // ----------------------------------------------------------------------
  // Timing figures, in milliseconds
  // ----------------------------------------------------------------------

  // Width of every millisecond count in the block.
  localparam int unsigned MS_W          = 16;
  // Fixed delay with the select pin high.
  localparam logic [15:0] DELAY_LONG_MS  = 16'h30D4;
  // Fixed delay with the select pin low.
  localparam logic [15:0] DELAY_SHORT_MS = 16'h1D4C;
  // Shortest delay that the adjustable setting supports.
  localparam logic [15:0] DELAY_MIN_MS   = 16'h03E8;
  // Longest delay that the adjustable setting supports.
  localparam logic [15:0] DELAY_MAX_MS   = 16'h4E20;
  // Length of the reboot pulse.
  localparam logic [15:0] PULSE_MS       = 16'h0190;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------

  // The reboot output is released after reset.
  localparam logic        REBOOT_N_RST   = 1'b1;
  // The millisecond counter is zero after reset.
  localparam logic [15:0] MS_RST         = 16'h0000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_DELAY,
    ST_PULSE,
    ST_RELEASE
  } rbt_state_t;

  // Two-way drive of the reboot pin: level and output enable.
  typedef struct packed {
    logic o;
    logic oe;
  } rbt_pin_t;

endpackage

/* rbt_sequencer.sv */
`timescale 1ns/1ps
// How it works
// - Both buttons held for delay: assert reboot.
// - Either button high keeps standby, no timing.
// - Fixed variant: select high 12.5s, low 7.5s.
// - Reboot pulse lasts 0.4s, then self-release.
// - Adjustable variant: delay from setting, 1s-20s.
// - Open drain drives low only; push-pull both.
// - Delay measured from second button going low.
module rbt_sequencer #(
  parameter bit          ADJUSTABLE  = 1'b0,
  parameter bit          OPEN_DRAIN  = 1'b1,
  parameter int unsigned TICK_CYCLES = rbt_pkg::TICK_CYCLES
) (
  input  wire logic             MCLK,
  input  wire logic             RSTN,
  input  wire logic             FIRST_BUTTON_INPUT,
  input  wire logic             SECOND_BUTTON_INPUT,
  input  wire logic             DELAY_SELECT_INPUT,
  input  wire logic [15:0]      DELAY_RESISTOR_PIN,
  input  wire logic             UNDERVOLTAGE_LOCKOUT,
  output rbt_pkg::rbt_pin_t     REBOOT_OUTPUT_N,
  output logic                  ACTIVE_MODE
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------

  // Present and next sequencer state.
  rbt_pkg::rbt_state_t state_q;
  rbt_pkg::rbt_state_t state_d;
  // Elapsed milliseconds of the running phase.
  logic [15:0]         ms;
  // Restarts the millisecond timer.
  logic                tmr_clr;
  // Both buttons are pressed.
  logic                both_low;
  // Delay that applies with the present pins.
  logic [15:0]         target_ms;
  // Registered level of the reboot line, low while rebooting.
  logic                reboot_n_q;

  // ----------------------------------------------------------------------
  // Delay selection
  // ----------------------------------------------------------------------

  // Chooses the delay; the adjustable setting is clamped into its range
  // because a wild resistor value must not make the timer useless.
  function automatic logic [15:0] pick_delay(input logic adj, input logic sel, input logic [15:0] set_ms);
    logic [15:0] v;
    v = set_ms;
    if (adj) begin
      if (v < rbt_pkg::DELAY_MIN_MS) begin
        v = rbt_pkg::DELAY_MIN_MS;
      end else if (v > rbt_pkg::DELAY_MAX_MS) begin
        v = rbt_pkg::DELAY_MAX_MS;
      end
    end else begin
      v = sel ? rbt_pkg::DELAY_LONG_MS : rbt_pkg::DELAY_SHORT_MS;
    end
    return v;
  endfunction

  // The select pin is assumed tied firmly; an open pin is not modelled.
  assign target_ms = pick_delay(ADJUSTABLE, DELAY_SELECT_INPUT, DELAY_RESISTOR_PIN);
  assign both_low  = !FIRST_BUTTON_INPUT && !SECOND_BUTTON_INPUT;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------

  // After a pulse a button must be let go before a new delay can start,
  // otherwise a held pair would reboot the host over and over.
  always_comb begin
    state_d = state_q;
    if (UNDERVOLTAGE_LOCKOUT) begin
      state_d = rbt_pkg::ST_STANDBY;
    end else begin
      unique case (state_q)
        rbt_pkg::ST_STANDBY: begin
          // Timing starts with the second button to go low.
          if (both_low) begin
            state_d = rbt_pkg::ST_DELAY;
          end
        end
        rbt_pkg::ST_DELAY: begin
          if (!both_low) begin
            state_d = rbt_pkg::ST_STANDBY;
          end else if (ms >= target_ms) begin
            state_d = rbt_pkg::ST_PULSE;
          end
        end
        rbt_pkg::ST_PULSE: begin
          if (ms >= rbt_pkg::PULSE_MS) begin
            state_d = rbt_pkg::ST_RELEASE;
          end
        end
        rbt_pkg::ST_RELEASE: begin
          if (!both_low) begin
            state_d = rbt_pkg::ST_STANDBY;
          end
        end
      endcase
    end
  end

  // Timer restarts on every state change and stays cleared when idle.
  assign tmr_clr = UNDERVOLTAGE_LOCKOUT || (state_q != state_d) ||
                   (state_q == rbt_pkg::ST_STANDBY) || (state_q == rbt_pkg::ST_RELEASE);

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Sequencer state, standby after reset.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= rbt_pkg::ST_STANDBY;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Millisecond timer
  // ----------------------------------------------------------------------

  rbt_ms_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk   (MCLK),
    .rst_n (RSTN),
    .clr   (tmr_clr),
    .ms_q  (ms)
  );

  // ----------------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------------

  // Registered from the next state, so the line is low exactly while the present state is the pulse.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      reboot_n_q <= rbt_pkg::REBOOT_N_RST;
    end else begin
      reboot_n_q <= (state_d != rbt_pkg::ST_PULSE);
    end
  end

  // Open drain only sinks; push-pull always drives the level.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      REBOOT_OUTPUT_N.o  <= OPEN_DRAIN ? 1'b0 : rbt_pkg::REBOOT_N_RST;
      REBOOT_OUTPUT_N.oe <= !OPEN_DRAIN;
    end else if (OPEN_DRAIN) begin
      REBOOT_OUTPUT_N.o  <= 1'b0;
      REBOOT_OUTPUT_N.oe <= (state_d == rbt_pkg::ST_PULSE);
    end else begin
      REBOOT_OUTPUT_N.o  <= (state_d != rbt_pkg::ST_PULSE);
      REBOOT_OUTPUT_N.oe <= 1'b1;
    end
  end

  // Active mode flag: a delay is being timed.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ACTIVE_MODE <= 1'b0;
    end else begin
      ACTIVE_MODE <= (state_d == rbt_pkg::ST_DELAY);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  // Held buttons that reach the delay start the pulse next cycle.
  property p_delay_done;
    (state_q == rbt_pkg::ST_DELAY) && both_low && (ms >= target_ms) && !UNDERVOLTAGE_LOCKOUT
      |=> (state_q == rbt_pkg::ST_PULSE) && !reboot_n_q;
  endproperty
  a_delay_done: assert property (p_delay_done) else $error("Reboot not asserted after delay.");

  // A released button aborts timing and leaves the timer at zero.
  property p_abort;
    (state_q == rbt_pkg::ST_DELAY) && !both_low |=> (state_q == rbt_pkg::ST_STANDBY) ##1 (ms == 16'h0000);
  endproperty
  a_abort: assert property (p_abort) else $error("Delay not aborted on release.");

  // Fixed variant delay follows the select pin.
  property p_fixed_delay;
    !ADJUSTABLE |-> (target_ms == (DELAY_SELECT_INPUT ? 16'h30D4 : 16'h1D4C));
  endproperty
  a_fixed_delay: assert property (p_fixed_delay) else $error("Wrong fixed delay.");

  // The pulse ends at its length and the line is released.
  property p_pulse_end;
    (state_q == rbt_pkg::ST_PULSE) && (ms >= rbt_pkg::PULSE_MS) && !UNDERVOLTAGE_LOCKOUT
      |=> reboot_n_q && (state_q == rbt_pkg::ST_RELEASE);
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("Pulse did not end.");

  // The line stays low until the pulse length has run out. Lockout may cut the
  // pulse short, so a cycle with lockout high is left out of this check.
  property p_pulse_hold;
    (state_q == rbt_pkg::ST_PULSE) && (ms < rbt_pkg::PULSE_MS) && !UNDERVOLTAGE_LOCKOUT |=> !reboot_n_q;
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("Pulse too short.");

  // Adjustable delay stays inside its supported range.
  property p_adj_range;
    ADJUSTABLE |-> (target_ms >= 16'h03E8) && (target_ms <= 16'h4E20);
  endproperty
  a_adj_range: assert property (p_adj_range) else $error("Adjustable delay out of range.");

  // Pin drive matches the output style and the internal level.
  property p_drive;
    OPEN_DRAIN ? (!REBOOT_OUTPUT_N.o && (REBOOT_OUTPUT_N.oe == !reboot_n_q))
               : (REBOOT_OUTPUT_N.oe && (REBOOT_OUTPUT_N.o == reboot_n_q));
  endproperty
  a_drive: assert property (p_drive) else $error("Pin drive wrong for output style.");

  // The second button going low starts timing from zero.
  property p_start;
    (state_q == rbt_pkg::ST_STANDBY) && both_low && !UNDERVOLTAGE_LOCKOUT
      |=> (state_q == rbt_pkg::ST_DELAY) && (ms == 16'h0000);
  endproperty
  a_start: assert property (p_start) else $error("Delay did not start on both low.");

  // Lockout forces standby, cleared timer and a released line.
  property p_lockout;
    UNDERVOLTAGE_LOCKOUT |=> (state_q == rbt_pkg::ST_STANDBY) && reboot_n_q && (ms == 16'h0000);
  endproperty
  a_lockout: assert property (p_lockout) else $error("Lockout did not clear the block.");

  property p_cov_reboot;
    (state_q == rbt_pkg::ST_DELAY) ##1 (state_q == rbt_pkg::ST_PULSE);
  endproperty
  c_cov_reboot: cover property (p_cov_reboot);

  property p_cov_abort;
    (state_q == rbt_pkg::ST_DELAY) ##1 (state_q == rbt_pkg::ST_STANDBY);
  endproperty
  c_cov_abort: cover property (p_cov_abort);

  property p_cov_back;
    (state_q == rbt_pkg::ST_RELEASE) ##1 (state_q == rbt_pkg::ST_STANDBY);
  endproperty
  c_cov_back: cover property (p_cov_back);

endmodule

/* two_button_reboot_timer_tb.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------------
// Instance dut is the fixed open-drain part, dut_adj the adjustable
// push-pull part. A short tick keeps the long delays affordable.
// Each part also sees the other part's setting pin, which it must ignore.
module two_button_reboot_timer_tb;
  localparam int TK = 4;                // Cycles per millisecond tick.
  logic              mclk = 1'b0;       // System clock.
  logic              rstn = 1'b0;       // Power-on reset, active low.
  logic              pa1 = 0, pa2 = 0;  // Presses on the fixed part.
  logic              pb1 = 0, pb2 = 0;  // Presses on the adjustable part.
  logic              sel_a = 1'b0;      // Delay select, always tied firmly.
  logic              uv_a = 1'b0;       // Lockout on the fixed part.
  logic              uv_b = 1'b0;       // Lockout on the adjustable part.
  logic [15:0]       res_b = 16'h03E8;  // Adjustable delay setting.
  logic              b1a, b2a, b1b, b2b; // Button lines.
  logic              host_a, host_b;    // Host reset levels.
  logic              act_a, act_b;      // Delay timing in progress.
  rbt_pkg::rbt_pin_t pin_a, pin_b;      // Pin drives.
  int                num_errors = 0;    // Mismatches seen.
  int                total_checks = 0;  // Comparisons made.

  always #4 mclk = ~mclk;

  rbt_btn_host host_a_i (.press_first(pa1), .press_second(pa2), .pin(pin_a),
    .first_btn_n(b1a), .second_btn_n(b2a), .host_rst_n(host_a));
  rbt_btn_host host_b_i (.press_first(pb1), .press_second(pb2), .pin(pin_b),
    .first_btn_n(b1b), .second_btn_n(b2b), .host_rst_n(host_b));
  rbt_sequencer #(.ADJUSTABLE(1'b0), .OPEN_DRAIN(1'b1), .TICK_CYCLES(TK)) dut (
    .MCLK(mclk), .RSTN(rstn), .FIRST_BUTTON_INPUT(b1a), .SECOND_BUTTON_INPUT(b2a),
    .DELAY_SELECT_INPUT(sel_a), .DELAY_RESISTOR_PIN(res_b), .UNDERVOLTAGE_LOCKOUT(uv_a),
    .REBOOT_OUTPUT_N(pin_a), .ACTIVE_MODE(act_a));
  rbt_sequencer #(.ADJUSTABLE(1'b1), .OPEN_DRAIN(1'b0), .TICK_CYCLES(TK)) dut_adj (
    .MCLK(mclk), .RSTN(rstn), .FIRST_BUTTON_INPUT(b1b), .SECOND_BUTTON_INPUT(b2b),
    .DELAY_SELECT_INPUT(sel_a), .DELAY_RESISTOR_PIN(res_b), .UNDERVOLTAGE_LOCKOUT(uv_b),
    .REBOOT_OUTPUT_N(pin_b), .ACTIVE_MODE(act_b));

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  // Exact comparison; an unknown never counts as a match.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Range comparison for measured cycle counts.
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, lo);
    end
  endtask
  // Outputs are looked at on the falling edge, where they have settled.
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Counts cycles to the pulse and its length, and keeps the drive seen in it.
  task automatic measure(input bit w, output logic [31:0] dl, output logic [31:0] pl,
                         output rbt_pkg::rbt_pin_t mid);
    dl = 0;
    pl = 0;
    while ((w ? host_b : host_a) !== 1'b0 && dl < 90000) begin
      @(negedge mclk);
      dl++;
    end
    mid = w ? pin_b : pin_a;
    while ((w ? host_b : host_a) === 1'b0 && pl < 3000) begin
      @(negedge mclk);
      pl++;
    end
  endtask
  // The delay and the pulse are judged against the millisecond figures.
  task automatic judge(input logic [31:0] dl, input logic [31:0] pl, input logic [31:0] ms);
    chk_rng(dl, ms * TK + 1, ms * TK + 6);
    chk_rng(pl, 32'(rbt_pkg::PULSE_MS) * TK, 32'(rbt_pkg::PULSE_MS) * TK + 4);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // One button, an abort, then a full short delay counted from the last press.
  task automatic t_short();
    logic [31:0] dl, pl;
    rbt_pkg::rbt_pin_t mid;
    @(posedge mclk);
    pa1 <= 1'b1;
    wait_n(500);
    chk(act_a, 1'b0);
    @(posedge mclk);
    pa2 <= 1'b1;
    wait_n(1000);
    chk(act_a, 1'b1);
    // Lockout in mid-delay stops timing and leaves the open-drain pin released.
    @(posedge mclk);
    uv_a <= 1'b1;
    wait_n(2);
    chk({act_a, host_a, pin_a}, 4'h4);
    @(posedge mclk);
    uv_a <= 1'b0;
    @(posedge mclk);
    pa2 <= 1'b0;
    wait_n(2);
    chk({act_a, host_a}, 2'b01);
    @(posedge mclk);
    pa2 <= 1'b1;
    measure(1'b0, dl, pl, mid);
    judge(dl, pl, 32'(rbt_pkg::DELAY_SHORT_MS));
    chk(mid, 2'b01);
    chk(pin_a, 2'b00);
    // Buttons still held: the pulse must not come again.
    wait_n(100);
    chk(host_a, 1'b1);
    @(posedge mclk);
    {pa1, pa2} <= 2'b00;
  endtask
  // Long fixed delay with the select pin high.
  task automatic t_long();
    logic [31:0] dl, pl;
    rbt_pkg::rbt_pin_t mid;
    @(posedge mclk);
    sel_a <= 1'b1;
    {pa1, pa2} <= 2'b11;
    measure(1'b0, dl, pl, mid);
    judge(dl, pl, 32'(rbt_pkg::DELAY_LONG_MS));
    @(posedge mclk);
    {pa1, pa2} <= 2'b00;
  endtask
  // Lockout in mid-pulse releases the pin and keeps the timer still.
  task automatic t_lock();
    int n;
    @(posedge mclk);
    res_b <= 16'h01F4;
    {pb1, pb2} <= 2'b11;
    n = 0;
    while (host_b !== 1'b0 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    uv_b <= 1'b1;
    wait_n(2);
    chk({act_b, host_b, pin_b}, 4'h7);
    wait_n(50);
    chk(act_b, 1'b0);
    @(posedge mclk);
    uv_b <= 1'b0;
    {pb1, pb2} <= 2'b00;
    wait_n(2);
  endtask
  // Adjustable delay from the setting, with push-pull drive.
  task automatic t_adj(input logic [15:0] set, input logic [31:0] ms);
    logic [31:0] dl, pl;
    rbt_pkg::rbt_pin_t mid;
    @(posedge mclk);
    res_b <= set;
    {pb1, pb2} <= 2'b11;
    measure(1'b1, dl, pl, mid);
    judge(dl, pl, ms);
    chk({mid, pin_b}, 4'h7);
    @(posedge mclk);
    {pb1, pb2} <= 2'b00;
  endtask

  // ----------------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------------
  task automatic final_report();
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // The adjustable part runs beside the long delay to keep the run short.
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    wait_n(2);
    chk({pin_a, pin_b, act_a, act_b}, 6'h0C);
    t_short();
    fork
      t_long();
      begin
        t_lock();
        t_adj(16'h01F4, 32'(rbt_pkg::DELAY_MIN_MS));
        t_adj(16'h07D0, 32'h0000_07D0);
      end
    join
    final_report();
  end

  // About 86000 cycles are expected; a hang is cut short well above that.
  initial begin
    repeat (99000) @(posedge mclk);
    num_errors++;
    final_report();
  end
endmodule
